// ### interrupt_request_logic.sv
// interrupt request logic with apb register slave, vectoring, return stack and wake-up
`timescale 1ns/10ps
`default_nettype none
`include "interrupt_request_logic_regs.svh"

// Summary of operation
// - global enable passes or blocks all requests
// - reset clears the global enable
// - service clears enable, stacks pc, vectors
// - return pops address and sets enable
// - flags set regardless of any enable but the per-pin change enables
// - clearing enable defers requests, keeps them pending
// - pin events vector within a bounded latency that depends on the phase
// - ext pin edge polarity from select bit
// - valid edge sets flag; enable gates it
// - ext wake only if enabled before sleep
// - analog pins read zero, raise nothing
// - timer0 rollover sets flag, enable gates
// - port change flag, per-pin and group enables
// - change during port access may be lost
// - ext flag set in q4-q1, sampled q1
// - seven peripheral flags with matching enables
// - wake runs next instruction, then vectors
// - only the return pc is saved
module interrupt_request_logic
  import interrupt_request_logic_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [5:0] i_port_pins,
  input wire logic i_port_access,
  input wire logic [7:0] i_timer0_count,
  input wire logic [7:0] i_periph_events,
  input wire logic i_sleep,
  input wire logic i_return_from_irq,
  input wire pc_t i_pc,
  output logic [5:0] o_pin_read,
  output logic o_irq_request,
  output logic o_vector_load,
  output pc_t o_vector_addr,
  output logic o_return_load,
  output pc_t o_return_pc,
  output logic o_wake
);
  logic [7:0] interrupt_control;
  logic [7:0] pin_change_enable;
  logic [7:0] peripheral_flags;
  logic [7:0] peripheral_enables;
  logic [7:0] pin_config;
  logic [7:0] next_interrupt_control;
  logic [7:0] next_peripheral_flags;
  logic [5:0] pin_sync;
  logic [5:0] pin_prev;
  logic [7:0] timer0_prev;
  logic ext_pending;
  logic sleep_prev;
  logic ext_enable_at_sleep;
  logic hold_count;
  phase_e phase;
  svc_state_e svc_state;
  svc_state_e next_svc_state;
  pc_t return_stack [`IRL_STACK_DEPTH];
  logic [2:0] stack_ptr;

  pin_input_sync u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_pins(i_port_pins),
    .o_pins(pin_sync)
  );

  // apb decode; one wait state, so writes land on the edge that samples pready
  wire bus_access = i_psel & i_penable & ~o_pready;
  wire bus_done = i_psel & i_penable & o_pready;
  wire bus_write = bus_done & i_pwrite & ~o_pslverr;
  wire hit_ctl = (i_paddr == `IRL_OFS_INTERRUPT_CONTROL);
  wire hit_ioc = (i_paddr == `IRL_OFS_PIN_CHANGE_ENABLE);
  wire hit_pfl = (i_paddr == `IRL_OFS_PERIPHERAL_FLAGS);
  wire hit_pen = (i_paddr == `IRL_OFS_PERIPHERAL_ENABLES);
  wire hit_cfg = (i_paddr == `IRL_OFS_PIN_CONFIG);
  wire addr_mapped = hit_ctl | hit_ioc | hit_pfl | hit_pen | hit_cfg;
  wire [7:0] read_byte = hit_ctl ? interrupt_control :
                         hit_ioc ? pin_change_enable :
                         hit_pfl ? peripheral_flags :
                         hit_pen ? peripheral_enables :
                         hit_cfg ? pin_config : 8'h00;

  // analog pins are masked before any edge or change logic sees them
  wire [5:0] analog_select = pin_config[5:0];
  wire [5:0] pin_level = pin_sync & ~analog_select;
  wire ext_edge_select = pin_config[`IRL_BIT_EXT_EDGE_SELECT];
  wire ext_now = pin_level[`IRL_EXT_PIN_INDEX];
  wire ext_was = pin_prev[`IRL_EXT_PIN_INDEX];
  wire ext_edge = ext_edge_select ? (ext_now & ~ext_was) : (~ext_now & ext_was);
  wire q4_or_q1 = (phase == PHASE_Q4) | (phase == PHASE_Q1);
  wire ext_commit = (ext_pending | ext_edge) & q4_or_q1;
  // a port operation in flight swallows a change; no flag is set for it
  wire [5:0] pin_changed = (pin_level ^ pin_prev) & pin_change_enable[5:0];
  wire port_change = (|pin_changed) & ~i_port_access;
  wire timer0_rollover = (timer0_prev == `IRL_TIMER0_MAX) &
                         (i_timer0_count == `IRL_TIMER0_ZERO);
  wire [2:0] core_set = {timer0_rollover, ext_commit, port_change};
  wire [7:0] periph_set = i_periph_events & `IRL_MASK_PERIPHERAL;

  wire global_irq_enable = interrupt_control[`IRL_BIT_GLOBAL_IRQ_ENABLE];
  wire peripheral_group_enable = interrupt_control[`IRL_BIT_PERIPHERAL_GROUP_ENABLE];
  wire [2:0] core_enables = interrupt_control[5:3];
  wire [2:0] core_flags = interrupt_control[2:0];
  wire periph_pending = peripheral_group_enable & (|(peripheral_flags & peripheral_enables));
  wire pending_any = (|(core_flags & core_enables)) | periph_pending;
  wire request_now = global_irq_enable & pending_any;

  // wake ignores the global enable; the ext source uses the enable held at sleep entry
  wire [2:0] wake_enables = {core_enables[2], ext_enable_at_sleep, core_enables[0]};
  wire wake_cause = (|(core_flags & wake_enables)) | periph_pending;
  wire sleep_entry = i_sleep & ~sleep_prev;
  wire sleep_exit = ~i_sleep & sleep_prev;

  // a request sampled at q1 is taken at q4 only if the enable still stands
  wire service = o_irq_request & global_irq_enable & (phase == PHASE_Q4) &
                 (svc_state == SVC_RUN) & ~i_sleep;
  wire [2:0] stack_top = stack_ptr - 3'd1;

  always_comb
  begin
    next_interrupt_control = interrupt_control;
    if (bus_write & hit_ctl)
    begin
      next_interrupt_control = i_pwdata[7:0];
    end
    // hardware set wins over a software clear in the same cycle
    next_interrupt_control[2:0] = next_interrupt_control[2:0] | core_set;
    if (i_return_from_irq)
    begin
      next_interrupt_control[`IRL_BIT_GLOBAL_IRQ_ENABLE] = 1'b1;
    end
    if (service)
    begin
      next_interrupt_control[`IRL_BIT_GLOBAL_IRQ_ENABLE] = 1'b0;
    end
  end

  always_comb
  begin
    next_peripheral_flags = peripheral_flags;
    if (bus_write & hit_pfl)
    begin
      next_peripheral_flags = i_pwdata[7:0] & `IRL_MASK_PERIPHERAL;
    end
    next_peripheral_flags = next_peripheral_flags | periph_set;
  end

  always_comb
  begin
    next_svc_state = svc_state;
    unique case (svc_state)
      SVC_RUN:
      begin
        if (sleep_entry)
        begin
          next_svc_state = SVC_SLEEP;
        end
      end
      SVC_SLEEP:
      begin
        if (sleep_exit)
        begin
          next_svc_state = SVC_HOLD;
        end
      end
      SVC_HOLD:
      begin
        if (hold_count & (phase == PHASE_Q4))
        begin
          next_svc_state = SVC_RUN;
        end
      end
      default:
      begin
        next_svc_state = SVC_RUN;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      interrupt_control <= `IRL_RST_INTERRUPT_CONTROL;
      pin_change_enable <= `IRL_RST_PIN_CHANGE_ENABLE;
      peripheral_flags <= `IRL_RST_PERIPHERAL_FLAGS;
      peripheral_enables <= `IRL_RST_PERIPHERAL_ENABLES;
      pin_config <= `IRL_RST_PIN_CONFIG;
    end
    else
    begin
      interrupt_control <= next_interrupt_control;
      peripheral_flags <= next_peripheral_flags;
      if (bus_write & hit_ioc)
      begin
        pin_change_enable <= i_pwdata[7:0] & `IRL_MASK_PIN_CHANGE;
      end
      if (bus_write & hit_pen)
      begin
        peripheral_enables <= i_pwdata[7:0] & `IRL_MASK_PERIPHERAL;
      end
      if (bus_write & hit_cfg)
      begin
        pin_config <= i_pwdata[7:0] & `IRL_MASK_PIN_CONFIG;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end
    else
    begin
      o_pready <= bus_access;
      o_pslverr <= bus_access & ~addr_mapped;
      if (bus_access & ~i_pwrite)
      begin
        o_prdata <= {24'h00_0000, read_byte};
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pin_prev <= 6'h00;
      timer0_prev <= 8'h00;
      ext_pending <= 1'b0;
      sleep_prev <= 1'b0;
      o_pin_read <= 6'h00;
    end
    else
    begin
      pin_prev <= pin_level;
      timer0_prev <= i_timer0_count;
      sleep_prev <= i_sleep;
      o_pin_read <= pin_level;
      // an edge outside q4-q1 waits here for the next allowed phase
      ext_pending <= (ext_pending | ext_edge) & ~q4_or_q1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      phase <= PHASE_Q1;
      svc_state <= SVC_RUN;
      hold_count <= 1'b0;
      ext_enable_at_sleep <= 1'b0;
      o_wake <= 1'b0;
    end
    else
    begin
      phase <= phase_e'(phase + 2'd1);
      svc_state <= next_svc_state;
      if (sleep_entry)
      begin
        ext_enable_at_sleep <= interrupt_control[`IRL_BIT_EXT_PIN_ENABLE];
      end
      if (svc_state != SVC_HOLD)
      begin
        hold_count <= 1'b0;
      end
      else if (phase == PHASE_Q4)
      begin
        hold_count <= 1'b1;
      end
      o_wake <= (svc_state == SVC_SLEEP) & i_sleep & wake_cause;
    end
  end

  // request is frozen between q1 samples but drops at once with the enable
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_irq_request <= 1'b0;
    end
    else if (phase == PHASE_Q1)
    begin
      o_irq_request <= request_now;
    end
    else
    begin
      o_irq_request <= o_irq_request & next_interrupt_control[`IRL_BIT_GLOBAL_IRQ_ENABLE];
    end
  end

  // only the pc goes on the stack; working state is software's job
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      stack_ptr <= 3'd0;
      o_vector_load <= 1'b0;
      o_vector_addr <= `IRL_VECTOR_ADDRESS;
      o_return_load <= 1'b0;
      o_return_pc <= 13'h0000;
    end
    else
    begin
      o_vector_load <= service;
      o_return_load <= i_return_from_irq & ~service;
      if (service)
      begin
        stack_ptr <= stack_ptr + 3'd1;
      end
      else if (i_return_from_irq)
      begin
        stack_ptr <= stack_top;
        o_return_pc <= return_stack[stack_top];
      end
    end
  end

  // the stack is circular: overflow overwrites the oldest entry, as the core expects
  always_ff @(posedge i_core_clk)
  begin
    if (service)
    begin
      return_stack[stack_ptr] <= i_pc;
    end
  end
endmodule // interrupt_request_logic
`default_nettype wire

// ### interrupt_request_logic_regs.svh
// register offsets, field positions, reset values, write masks and constants of the interrupt logic
`ifndef INTERRUPT_REQUEST_LOGIC_REGS_SVH
`define INTERRUPT_REQUEST_LOGIC_REGS_SVH

`define IRL_OFS_INTERRUPT_CONTROL 8'h00
`define IRL_OFS_PIN_CHANGE_ENABLE 8'h04
`define IRL_OFS_PERIPHERAL_FLAGS 8'h08
`define IRL_OFS_PERIPHERAL_ENABLES 8'h0c
`define IRL_OFS_PIN_CONFIG 8'h10

`define IRL_BIT_GLOBAL_IRQ_ENABLE 7
`define IRL_BIT_PERIPHERAL_GROUP_ENABLE 6
`define IRL_BIT_TIMER0_OVERFLOW_ENABLE 5
`define IRL_BIT_EXT_PIN_ENABLE 4
`define IRL_BIT_PORT_CHANGE_ENABLE 3
`define IRL_BIT_TIMER0_OVERFLOW_FLAG 2
`define IRL_BIT_EXT_PIN_FLAG 1
`define IRL_BIT_PORT_CHANGE_FLAG 0

`define IRL_BIT_EXT_EDGE_SELECT 6
`define IRL_EXT_PIN_INDEX 2

`define IRL_RST_INTERRUPT_CONTROL 8'h00
`define IRL_RST_PIN_CHANGE_ENABLE 8'h00
`define IRL_RST_PERIPHERAL_FLAGS 8'h00
`define IRL_RST_PERIPHERAL_ENABLES 8'h00
`define IRL_RST_PIN_CONFIG 8'h00
`define IRL_MASK_PERIPHERAL 8'hef
`define IRL_MASK_PIN_CHANGE 8'h3f
`define IRL_MASK_PIN_CONFIG 8'h7f

`define IRL_TIMER0_MAX 8'hff
`define IRL_TIMER0_ZERO 8'h00
`define IRL_VECTOR_ADDRESS 13'h0004
`define IRL_STACK_DEPTH 8

`endif

// ### interrupt_request_logic_pkg.sv
// types shared by the interrupt request logic
`default_nettype none
package interrupt_request_logic_pkg;
  typedef enum logic [1:0] {
    PHASE_Q1 = 2'b00,
    PHASE_Q2 = 2'b01,
    PHASE_Q3 = 2'b10,
    PHASE_Q4 = 2'b11
  } phase_e;

  typedef enum logic [1:0] {
    SVC_RUN = 2'b00,
    SVC_SLEEP = 2'b01,
    SVC_HOLD = 2'b10
  } svc_state_e;

  typedef logic [12:0] pc_t;
endpackage
`default_nettype wire

// ### pin_input_sync.sv
// two-flop synchronisers for the asynchronous port pins
`timescale 1ns/10ps
`default_nettype none
module pin_input_sync
  import interrupt_request_logic_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [5:0] i_pins,
  output logic [5:0] o_pins
);
  logic [5:0] stage1;

  for (genvar g = 0; g < 6; g++)
  begin : g_sync
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        stage1[g] <= 1'b0;
        o_pins[g] <= 1'b0;
      end
      else
      begin
        stage1[g] <= i_pins[g];
        o_pins[g] <= stage1[g];
      end
    end
  end
endmodule // pin_input_sync
`default_nettype wire

// ### interrupt_request_logic_assertions.sv
// port assertions for the interrupt request logic
`timescale 1ns/10ps
`default_nettype none
module irl_checker
  import interrupt_request_logic_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_sleep,
  input wire logic i_return_from_irq,
  input wire logic o_irq_request,
  input wire logic o_vector_load,
  input wire pc_t o_vector_addr,
  input wire logic o_return_load
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  apb_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("no ready after access");
  apb_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  apb_err_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  vec_addr_a: assert property (o_vector_load |-> o_vector_addr == 13'h0004 && !o_irq_request)
    else $error("bad vector or request kept");
  vec_cause_a: assert property (o_vector_load |-> $past(o_irq_request) ##1 !o_vector_load)
    else $error("vector without request");
  ret_load_a: assert property (i_return_from_irq |=> o_return_load || o_vector_load)
    else $error("return not loaded");
  ret_cause_a: assert property (o_return_load |-> $past(i_return_from_irq))
    else $error("return load without return");
  reset_quiet_a: assert property ($rose(i_reset_n) |-> !o_irq_request ##1 !o_irq_request)
    else $error("request right after reset");
  irq_latency_a: assert property ($rose(o_irq_request) && !i_sleep |->
    ##[1:12] (o_vector_load || !o_irq_request || i_sleep))
    else $error("request not serviced in time");
endmodule // irl_checker
bind interrupt_request_logic irl_checker chk_u (
  .i_core_clk, .i_reset_n, .i_psel, .i_penable, .o_pready, .o_pslverr,
  .i_sleep, .i_return_from_irq, .o_irq_request, .o_vector_load,
  .o_vector_addr, .o_return_load
);
`default_nettype wire

// ### core_model.sv
// core sequencer model: steps the pc, takes vectors and returns
`timescale 1ns/10ps
`default_nettype none
module core_model
  import interrupt_request_logic_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_vector_load,
  input wire pc_t i_vector_addr,
  input wire logic i_return_load,
  input wire pc_t i_return_pc,
  input wire logic i_ret_cmd,
  output pc_t o_pc,
  output pc_t o_saved_pc,
  output logic o_in_isr,
  output logic o_return_from_irq
);
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_pc <= 13'h0100;
      o_saved_pc <= 13'h0000;
      o_in_isr <= 1'b0;
      o_return_from_irq <= 1'b0;
    end
    else
    begin
      o_return_from_irq <= i_ret_cmd;
      o_pc <= o_pc + 13'h0001;
      if (i_vector_load)
      begin
        // the design took the pc one edge before this pulse
        o_saved_pc <= o_pc - 13'h0001;
        o_pc <= i_vector_addr;
        o_in_isr <= 1'b1;
      end
      else if (i_return_load)
      begin
        o_pc <= i_return_pc;
        o_in_isr <= 1'b0;
      end
    end
  end
endmodule // core_model
`default_nettype wire

// ### interrupt_request_logic_bench.sv
// self-checking bench for the interrupt request logic
`timescale 1ns/10ps
`default_nettype none
module interrupt_request_logic_bench
  import interrupt_request_logic_pkg::*;
;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sleep = 0, ret_cmd = 0, pacc = 0;
  logic [7:0] paddr = 8'h00, tmr = 8'h00, ev = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, ret, irq, vload, rload, wake, in_isr;
  logic [5:0] pins = 6'h3f, pin_read;
  pc_t pc, vaddr, rpc, saved;
  int n_errors = 0, samples_checked = 0;
  interrupt_request_logic dut_u (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_port_pins(pins), .i_port_access(pacc),
    .i_timer0_count(tmr), .i_periph_events(ev), .i_sleep(sleep),
    .i_return_from_irq(ret), .i_pc(pc), .o_pin_read(pin_read), .o_irq_request(irq),
    .o_vector_load(vload), .o_vector_addr(vaddr), .o_return_load(rload),
    .o_return_pc(rpc), .o_wake(wake));
  core_model core_u (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_vector_load(vload), .i_vector_addr(vaddr),
    .i_return_load(rload), .i_return_pc(rpc), .i_ret_cmd(ret_cmd), .o_pc(pc),
    .o_saved_pc(saved), .o_in_isr(in_isr), .o_return_from_irq(ret));
  initial
  begin
    forever #20 clk = ~clk;
  end
  task automatic wrap_up;
    if (n_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // holds the request until ready is seen at an edge, then idles one cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1)
    begin
      n_errors++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, exp});
  endtask
  task automatic wait_isr(input logic v);
    int k;
    k = 0;
    while (in_isr !== v && k < 40)
    begin
      @(posedge clk);
      k++;
    end
    chk(32'(in_isr), 32'(v));
    if (in_isr !== v)
      wrap_up();
  endtask
  task automatic do_return;
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    wait_isr(1'b0);
    chk(32'(pc), 32'(saved));
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++)
      rdchk(8'(i * 4), 8'h00);
    apb(1'b0, 8'h14, 8'h00);
    chk(32'(err), 32'h1);
    apb(1'b1, 8'h0c, 8'hff);
    rdchk(8'h0c, 8'hef);
    apb(1'b1, 8'h0c, 8'h01);
    apb(1'b1, 8'h00, 8'h20);
    tmr <= 8'hff;
    @(posedge clk);
    tmr <= 8'h00;
    repeat (4) @(posedge clk);
    rdchk(8'h00, 8'h24);
    chk(32'(irq), 32'h0);
    apb(1'b1, 8'h00, 8'ha4);
    wait_isr(1'b1);
    chk(32'(pc), 32'h4);
    rdchk(8'h00, 8'h24);
    apb(1'b1, 8'h00, 8'h20);
    do_return();
    rdchk(8'h00, 8'ha0);
    ev <= 8'hff;
    @(posedge clk);
    ev <= 8'h00;
    repeat (2) @(posedge clk);
    rdchk(8'h08, 8'hef);
    chk(32'(irq), 32'h0);
    apb(1'b1, 8'h00, 8'he0);
    wait_isr(1'b1);
    apb(1'b1, 8'h08, 8'h00);
    rdchk(8'h08, 8'h00);
    do_return();
    apb(1'b1, 8'h00, 8'h60);
    apb(1'b1, 8'h08, 8'h01);
    repeat (8) @(posedge clk);
    chk(32'(irq), 32'h0);
    apb(1'b1, 8'h00, 8'he0);
    wait_isr(1'b1);
    apb(1'b1, 8'h08, 8'h00);
    do_return();
    for (int s = 0; s < 2; s++)
    begin
      apb(1'b1, 8'h10, {1'b0, s[0], 6'h00});
      apb(1'b1, 8'h00, 8'h00);
      pins[2] <= 1'b0;
      repeat (12) @(posedge clk);
      rdchk(8'h00, {6'h00, ~s[0], 1'b0});
      apb(1'b1, 8'h00, 8'h00);
      pins[2] <= 1'b1;
      repeat (12) @(posedge clk);
      rdchk(8'h00, {6'h00, s[0], 1'b0});
    end
    apb(1'b1, 8'h00, 8'h00);
    // pin low under rising select first, so only the masked rising edge is under test
    pins[2] <= 1'b0;
    apb(1'b1, 8'h10, 8'h44);
    pins[2] <= 1'b1;
    repeat (12) @(posedge clk);
    chk(32'(pin_read), 32'h3b);
    rdchk(8'h00, 8'h00);
    apb(1'b1, 8'h10, 8'h00);
    apb(1'b1, 8'h04, 8'h02);
    apb(1'b1, 8'h00, 8'h90);
    pins[0] <= 1'b0;
    repeat (12) @(posedge clk);
    rdchk(8'h00, 8'h90);
    pins[1] <= 1'b0;
    repeat (12) @(posedge clk);
    rdchk(8'h00, 8'h91);
    apb(1'b1, 8'h00, 8'h90);
    pacc <= 1'b1;
    pins[1] <= 1'b1;
    repeat (12) @(posedge clk);
    pacc <= 1'b0;
    rdchk(8'h00, 8'h90);
    sleep <= 1'b1;
    repeat (12) @(posedge clk);
    chk(32'(wake), 32'h0);
    pins[2] <= 1'b0;
    repeat (12) @(posedge clk);
    chk(32'(wake), 32'h1);
    sleep <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(in_isr), 32'h0);
    wait_isr(1'b1);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(8'h00, 8'h00);
    wrap_up();
  end
endmodule // interrupt_request_logic_bench
`default_nettype wire
